// ### logic/psc_map.svh
// register offsets, field positions, reset values for the pll2 control
`ifndef PSC_MAP_SVH
`define PSC_MAP_SVH

`define PSC_I2C_ADDR   7'h6a
`define PSC_A_BIAS     8'h11
`define PSC_A_ACQ      8'h1f
`define PSC_A_FRAC_HI  8'h19
`define PSC_A_FRAC_MOD 8'h1a
`define PSC_A_MOD_LO   8'h1b
`define PSC_A_INT_FB   8'h1c
`define PSC_A_SDM_PD   8'h20
`define PSC_A_REF      8'h21
`define PSC_A_P2_DIV   8'h22
`define PSC_A_P3_DIV   8'h23
`define PSC_A_SYNC     8'h24
`define PSC_A_STEP_SZ  8'h25
`define PSC_A_STEP_LO  8'h26
`define PSC_A_STEP_HI  8'h27
`define PSC_A_ALT_FH   8'h38
`define PSC_A_ALT_FM   8'h39
`define PSC_A_ALT_ML   8'h3a
`define PSC_A_ALT_INT  8'h3b
`define PSC_A_ALT_P2   8'h3c
`define PSC_A_ALT_P3   8'h3d

`define PSC_BLEED_BIT  2
`define PSC_SDMPD_BIT  4
`define PSC_REF_BIT    1
`define PSC_SYNC_BIT   0
`define PSC_ACQ_BIT    0

`define PSC_NB_OFFSET  8'h50
`define PSC_SPREAD_DIV 26'h00000c8
`define PSC_MIN_RATE   7'h02
`define PSC_MIN_STEPS  9'h001

`define PSC_RST_NB     6'h13
`define PSC_RST_FRAC   12'h14d
`define PSC_RST_MOD    12'h271
`define PSC_RST_ANB    6'h14
`define PSC_RST_AFRAC  12'h0c6
`define PSC_RST_AMOD   12'h271
`define PSC_RST_V      3'h4
`define PSC_RST_D2     5'h04
`define PSC_RST_D3     5'h10
`define PSC_RST_STEP   8'hf9
`define PSC_RST_CNT    9'h02d
`define PSC_RST_RATE   7'h09

`endif

// ### logic/psc_pkg.sv
// types shared by the pll2 spread and alt_map_select_pin control
`default_nettype none
package psc_pkg;

	typedef struct packed {
		logic [5:0]  nb;
		logic [11:0] frac;
		logic [11:0] modw;
		logic [2:0]  v2;
		logic [4:0]  d2;
		logic [2:0]  v3;
		logic [4:0]  d3;
	} psc_map_t;

	typedef struct packed {
		logic signed [7:0] step;
		logic [8:0]        cnt;
		logic [6:0]        rate;
	} psc_spread_t;

	typedef struct packed {
		logic [6:0]         div_cnt;
		logic [8:0]         step_cnt;
		logic               down;
		logic signed [17:0] offs;
	} psc_tri_t;

	typedef enum logic [2:0] {
		I_IDLE     = 3'b000,
		I_ADDR     = 3'b001,
		I_ADDR_ACK = 3'b010,
		I_SUB      = 3'b011,
		I_SUB_ACK  = 3'b100,
		I_DATA     = 3'b101,
		I_DATA_ACK = 3'b110,
		I_SKIP     = 3'b111
	} psc_i2c_t;

	typedef struct packed {
		psc_i2c_t           fsm;
		logic [3:0]         bitc;
		logic [7:0]         shift;
		logic [7:0]         sub;
		logic               scl_q;
		logic               sda_q;
		logic               sda_oen;
		logic               sda_o;
		psc_map_t           prim;
		psc_map_t           alt;
		psc_spread_t        spw;
		psc_spread_t        spa;
		logic               bleed;
		logic               sdm_pd;
		logic               refdiv;
		logic               sync;
		logic               acq_bit;
		logic               alt_map_select_pin_q;
		logic               spread_q;
		logic [7:0]         nb_o;
		logic signed [17:0] frac_o;
		logic [11:0]        mod_o;
		logic [2:0]         v2_o;
		logic [4:0]         d2_o;
		logic [2:0]         v3_o;
		logic [4:0]         d3_o;
		logic               sync_o;
		logic               acq_o;
	} psc_ctl_t;

endpackage
`default_nettype wire

// ### logic/psc_tri.sv
// triangle generator stepping the fractional offset down and up
`timescale 1ns/10ps
`default_nettype none
`include "psc_map.svh"

module psc_tri (
	// clock and reset
	input  wire logic                clk_in,
	input  wire logic                resetn_in,
	// control
	input  wire logic                run_in,
	input  wire psc_pkg::psc_spread_t cfg_in,
	input  wire logic [19:0]         total_in,
	// result
	output logic signed [17:0]       offs_out
);

	psc_pkg::psc_tri_t q_reg;
	psc_pkg::psc_tri_t q_next;
	logic signed [7:0]  step_e;
	logic [6:0]         rate_e;
	logic [8:0]         cnt_e;
	logic               tick;
	logic signed [17:0] cand;
	logic [17:0]        mag;
	logic [25:0]        scaled;

	always_comb begin
		q_next = q_reg;
		step_e = (cfg_in.step > 8'sh00) ? 8'sh00 : cfg_in.step;
		// out of range settings clamp to the nearest legal value
		rate_e = (cfg_in.rate < `PSC_MIN_RATE) ? `PSC_MIN_RATE : cfg_in.rate;
		cnt_e = (cfg_in.cnt == 9'h000) ? `PSC_MIN_STEPS : cfg_in.cnt;
		tick = (q_reg.div_cnt == rate_e - 7'h01);
		cand = q_reg.down ? q_reg.offs + {{10{step_e[7]}}, step_e}
			: q_reg.offs - {{10{step_e[7]}}, step_e};
		mag = 18'h00000 - cand;
		scaled = {8'h00, mag} * `PSC_SPREAD_DIV;
		if (!run_in) begin
			q_next.div_cnt = 7'h00;
			q_next.step_cnt = 9'h000;
			q_next.down = 1'b1;
			q_next.offs = 18'sh00000;
		end else begin
			q_next.div_cnt = tick ? 7'h00 : q_reg.div_cnt + 7'h01;
			if (tick) begin
				if (q_reg.down) begin
					if (scaled <= {6'h00, total_in})
						q_next.offs = cand;
				end else begin
					q_next.offs = (cand > 18'sh00000) ? 18'sh00000 : cand;
				end
				if (q_reg.step_cnt == cnt_e - 9'h001) begin
					q_next.step_cnt = 9'h000;
					q_next.down = ~q_reg.down;
				end else begin
					q_next.step_cnt = q_reg.step_cnt + 9'h001;
				end
			end
		end
		if (!resetn_in) begin
			q_next = '0;
			q_next.down = 1'b1;
		end
	end

	always_ff @(posedge clk_in) begin
		q_reg <= q_next;
	end

	assign offs_out = q_reg.offs;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);

	idle_offset_zero_a: assert property (
		!run_in |=> q_reg.offs == 18'sh00000)
		else $error("offset not cleared when spread is off");
	no_upspread_a: assert property (
		q_reg.offs <= 18'sh00000)
		else $error("offset went above nominal");
	step_on_tick_a: assert property (
		run_in && !tick ##1 run_in |-> $stable(q_reg.offs))
		else $error("offset moved between divided ticks");
	half_turn_a: assert property (
		run_in && tick && q_reg.step_cnt == cnt_e - 9'h001 ##1 run_in
		|-> q_reg.down != $past(q_reg.down))
		else $error("triangle did not turn after step count");
	cover_turn_up_c: cover property (run_in && tick && !q_reg.down);
	cover_peak_c: cover property (run_in && q_reg.offs < 18'sh00000);

endmodule
`default_nettype wire

// ### logic/psc_ctrl.sv
// pll2 fractional synth control: i2c settings, alt_map_select_pin map, spread
`timescale 1ns/10ps
`default_nettype none
`include "psc_map.svh"

module psc_ctrl (
	// clock and reset
	input  wire logic         CLK_IN,
	input  wire logic         RESETN_IN,
	// serial configuration port
	input  wire logic         SCL_IN,
	input  wire logic         SDA_IN,
	output logic              SDA_OUT,
	output logic              SDA_OEN_OUT,
	// control pins
	input  wire logic         SPREAD_EN_IN,
	input  wire logic         ALT_MAP_SEL_IN,
	// synthesizer settings
	output logic [7:0]        FB_INT_OUT,
	output logic signed [17:0] SDM_FRAC_OUT,
	output logic [11:0]       MOD_WORD_OUT,
	output logic [2:0]        P2_VCO_DIV_OUT,
	output logic [4:0]        P2_CH_DIV_OUT,
	output logic [2:0]        P3_VCO_DIV_OUT,
	output logic [4:0]        P3_CH_DIV_OUT,
	// modes and events
	output logic              PAIR_SYNC_OUT,
	output logic              REF_DIV_TWO_OUT,
	output logic              NEW_ACQ_OUT,
	output logic              SPREAD_ACT_OUT,
	output logic              BLEED_OUT,
	output logic              SDM_PD_OUT
);

	psc_pkg::psc_ctl_t q_reg;
	psc_pkg::psc_ctl_t q_next;
	psc_pkg::psc_map_t map_sel;
	logic               scl_rise;
	logic               scl_fall;
	logic               start_c;
	logic               stop_c;
	logic               wr_en;
	logic [7:0]         wr_dat;
	logic [7:0]         nb_eff;
	logic [19:0]        total;
	logic signed [17:0] tri_offs;
	logic signed [17:0] frac_ext;

	// bus line edges; pins arrive synchronous to the clock
	assign scl_rise = SCL_IN & ~q_reg.scl_q;
	assign scl_fall = ~SCL_IN & q_reg.scl_q;
	assign start_c = q_reg.scl_q & SCL_IN & q_reg.sda_q & ~SDA_IN;
	assign stop_c = q_reg.scl_q & SCL_IN & ~q_reg.sda_q & SDA_IN;

	assign map_sel = q_reg.alt_map_select_pin_q ? q_reg.alt : q_reg.prim;
	// plus 80; eight bits, as 63 plus 80 passes 127
	assign nb_eff = {2'b00, map_sel.nb} + `PSC_NB_OFFSET;
	assign total = {12'h000, nb_eff} * {8'h00, map_sel.modw}
		+ {8'h00, map_sel.frac};
	assign frac_ext = {6'h00, map_sel.frac};

	// triangle runs while spread pin is high
	psc_tri u_tri (
		.clk_in    (CLK_IN),
		.resetn_in (RESETN_IN),
		.run_in    (q_reg.spread_q),
		.cfg_in    (q_reg.spa),
		.total_in  (total),
		.offs_out  (tri_offs)
	);

	always_comb begin
		q_next = q_reg;
		wr_en = 1'b0;
		wr_dat = q_reg.shift;
		q_next.scl_q = SCL_IN;
		q_next.sda_q = SDA_IN;
		q_next.acq_o = 1'b0;

		// write-only slave; reads are not acknowledged
		if (start_c) begin
			q_next.fsm = psc_pkg::I_ADDR;
			q_next.bitc = 4'h0;
			q_next.sda_oen = 1'b1;
		end else if (stop_c) begin
			q_next.fsm = psc_pkg::I_IDLE;
			q_next.sda_oen = 1'b1;
		end else begin
			case (q_reg.fsm)
				psc_pkg::I_ADDR,
				psc_pkg::I_SUB,
				psc_pkg::I_DATA: begin
					if (scl_rise) begin
						q_next.shift = {q_reg.shift[6:0], SDA_IN};
						q_next.bitc = q_reg.bitc + 4'h1;
					end else if (scl_fall && q_reg.bitc == 4'h8) begin
						q_next.bitc = 4'h0;
						q_next.sda_oen = 1'b0;
						if (q_reg.fsm == psc_pkg::I_ADDR) begin
							if (q_reg.shift == {`PSC_I2C_ADDR, 1'b0}) begin
								q_next.fsm = psc_pkg::I_ADDR_ACK;
							end else begin
								q_next.fsm = psc_pkg::I_SKIP;
								q_next.sda_oen = 1'b1;
							end
						end else if (q_reg.fsm == psc_pkg::I_SUB) begin
							q_next.sub = q_reg.shift;
							q_next.fsm = psc_pkg::I_SUB_ACK;
						end else begin
							wr_en = 1'b1;
							q_next.sub = q_reg.sub + 8'h01;
							q_next.fsm = psc_pkg::I_DATA_ACK;
						end
					end
				end
				psc_pkg::I_ADDR_ACK: begin
					if (scl_fall) begin
						q_next.sda_oen = 1'b1;
						q_next.fsm = psc_pkg::I_SUB;
					end
				end
				psc_pkg::I_SUB_ACK,
				psc_pkg::I_DATA_ACK: begin
					if (scl_fall) begin
						q_next.sda_oen = 1'b1;
						q_next.fsm = psc_pkg::I_DATA;
					end
				end
				psc_pkg::I_IDLE,
				psc_pkg::I_SKIP: begin
					q_next.sda_oen = 1'b1;
				end
				default: begin
					q_next.fsm = psc_pkg::I_IDLE;
					q_next.sda_oen = 1'b1;
				end
			endcase
		end

		// register writes
		if (wr_en) begin
			case (q_reg.sub)
				`PSC_A_BIAS: q_next.bleed = wr_dat[`PSC_BLEED_BIT];
				`PSC_A_ACQ: q_next.acq_bit = wr_dat[`PSC_ACQ_BIT];
				`PSC_A_FRAC_HI: q_next.prim.frac[11:4] = wr_dat;
				`PSC_A_FRAC_MOD: begin
					q_next.prim.frac[3:0] = wr_dat[7:4];
					q_next.prim.modw[11:8] = wr_dat[3:0];
				end
				`PSC_A_MOD_LO: q_next.prim.modw[7:0] = wr_dat;
				`PSC_A_INT_FB: q_next.prim.nb = wr_dat[5:0];
				`PSC_A_SDM_PD: q_next.sdm_pd = wr_dat[`PSC_SDMPD_BIT];
				`PSC_A_REF: q_next.refdiv = wr_dat[`PSC_REF_BIT];
				`PSC_A_P2_DIV: begin
					q_next.prim.v2 = wr_dat[7:5];
					q_next.prim.d2 = wr_dat[4:0];
				end
				`PSC_A_P3_DIV: begin
					q_next.prim.v3 = wr_dat[7:5];
					q_next.prim.d3 = wr_dat[4:0];
				end
				`PSC_A_SYNC: q_next.sync = wr_dat[`PSC_SYNC_BIT];
				`PSC_A_STEP_SZ: q_next.spw.step = wr_dat;
				`PSC_A_STEP_LO: q_next.spw.cnt[7:0] = wr_dat;
				`PSC_A_STEP_HI: begin
					q_next.spw.cnt[8] = wr_dat[7];
					q_next.spw.rate = wr_dat[6:0];
				end
				`PSC_A_ALT_FH: q_next.alt.frac[11:4] = wr_dat;
				`PSC_A_ALT_FM: begin
					q_next.alt.frac[3:0] = wr_dat[7:4];
					q_next.alt.modw[11:8] = wr_dat[3:0];
				end
				`PSC_A_ALT_ML: q_next.alt.modw[7:0] = wr_dat;
				`PSC_A_ALT_INT: q_next.alt.nb = wr_dat[5:0];
				`PSC_A_ALT_P2: begin
					q_next.alt.v2 = wr_dat[7:5];
					q_next.alt.d2 = wr_dat[4:0];
				end
				`PSC_A_ALT_P3: begin
					q_next.alt.v3 = wr_dat[7:5];
					q_next.alt.d3 = wr_dat[4:0];
				end
				default: ;
			endcase
		end

		// adopt spread settings on pin rise
		q_next.spread_q = SPREAD_EN_IN;
		if (SPREAD_EN_IN && !q_reg.spread_q)
			q_next.spa = q_reg.spw;

		q_next.alt_map_select_pin_q = ALT_MAP_SEL_IN;
		if (ALT_MAP_SEL_IN != q_reg.alt_map_select_pin_q)
			q_next.acq_o = 1'b1;
		// software restart: one written then zero
		if (wr_en && q_reg.sub == `PSC_A_ACQ && q_reg.acq_bit
			&& !wr_dat[`PSC_ACQ_BIT])
			q_next.acq_o = 1'b1;

		q_next.nb_o = nb_eff;
		q_next.mod_o = map_sel.modw;
		q_next.frac_o = frac_ext + tri_offs;
		q_next.v2_o = map_sel.v2;
		q_next.d2_o = map_sel.d2;
		q_next.v3_o = map_sel.v3;
		q_next.d3_o = map_sel.d3;
		// sync only with equal vco dividers
		q_next.sync_o = q_reg.sync && (map_sel.v2 == map_sel.v3);

		if (!RESETN_IN) begin
			q_next = '0;
			q_next.scl_q = 1'b1;
			q_next.sda_q = 1'b1;
			q_next.sda_oen = 1'b1;
			q_next.sdm_pd = 1'b1;
			q_next.prim.nb = `PSC_RST_NB;
			q_next.prim.frac = `PSC_RST_FRAC;
			q_next.prim.modw = `PSC_RST_MOD;
			q_next.prim.v2 = `PSC_RST_V;
			q_next.prim.d2 = `PSC_RST_D2;
			q_next.prim.v3 = `PSC_RST_V;
			q_next.prim.d3 = `PSC_RST_D3;
			q_next.alt.nb = `PSC_RST_ANB;
			q_next.alt.frac = `PSC_RST_AFRAC;
			q_next.alt.modw = `PSC_RST_AMOD;
			q_next.alt.v2 = `PSC_RST_V;
			q_next.alt.d2 = `PSC_RST_D2;
			q_next.alt.v3 = `PSC_RST_V;
			q_next.alt.d3 = `PSC_RST_D3;
			q_next.spw.step = `PSC_RST_STEP;
			q_next.spw.cnt = `PSC_RST_CNT;
			q_next.spw.rate = `PSC_RST_RATE;
			q_next.spa = q_next.spw;
		end
	end

	always_ff @(posedge CLK_IN) begin
		q_reg <= q_next;
	end

	assign SDA_OUT = q_reg.sda_o;
	assign SDA_OEN_OUT = q_reg.sda_oen;
	assign FB_INT_OUT = q_reg.nb_o;
	assign SDM_FRAC_OUT = q_reg.frac_o;
	assign MOD_WORD_OUT = q_reg.mod_o;
	assign P2_VCO_DIV_OUT = q_reg.v2_o;
	assign P2_CH_DIV_OUT = q_reg.d2_o;
	assign P3_VCO_DIV_OUT = q_reg.v3_o;
	assign P3_CH_DIV_OUT = q_reg.d3_o;
	assign PAIR_SYNC_OUT = q_reg.sync_o;
	assign REF_DIV_TWO_OUT = q_reg.refdiv;
	assign NEW_ACQ_OUT = q_reg.acq_o;
	assign SPREAD_ACT_OUT = q_reg.spread_q;
	assign BLEED_OUT = q_reg.bleed;
	assign SDM_PD_OUT = q_reg.sdm_pd;

	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!RESETN_IN);

	alt_map_select_pin_acq_a: assert property (
		ALT_MAP_SEL_IN != q_reg.alt_map_select_pin_q |=> NEW_ACQ_OUT)
		else $error("no acquisition after alt_map_select_pin change");
	pair_sync_a: assert property (
		PAIR_SYNC_OUT |-> P2_VCO_DIV_OUT == P3_VCO_DIV_OUT)
		else $error("pair sync with unequal vco dividers");
	nb_offset_a: assert property (
		q_reg.alt_map_select_pin_q == $past(q_reg.alt_map_select_pin_q)
		|=> FB_INT_OUT == {2'b00, $past(map_sel.nb)} + 8'h50)
		else $error("integer feedback lacks the fixed offset");
	alt_map_a: assert property (
		q_reg.alt_map_select_pin_q |=> MOD_WORD_OUT == $past(q_reg.alt.modw))
		else $error("alternate modulus not applied");
	spread_latch_a: assert property (
		!(SPREAD_EN_IN && !q_reg.spread_q) |=> $stable(q_reg.spa))
		else $error("spread settings changed without pin rise");
	common_bleed_a: assert property (
		!wr_en ##1 $changed(q_reg.alt_map_select_pin_q) |-> $stable(BLEED_OUT))
		else $error("bleed changed with the map");
	common_sdm_pd_a: assert property (
		!wr_en ##1 $changed(q_reg.alt_map_select_pin_q) |-> $stable(SDM_PD_OUT))
		else $error("modulator power-down changed with the map");
	ref_div_sel_a: assert property (
		wr_en && q_reg.sub == `PSC_A_REF
		|=> REF_DIV_TWO_OUT == $past(wr_dat[`PSC_REF_BIT]))
		else $error("reference divider bit not applied");
	prim_map_a: assert property (
		!q_reg.alt_map_select_pin_q |=> MOD_WORD_OUT == $past(q_reg.prim.modw))
		else $error("primary modulus not applied");
	port_div_a: assert property (
		1'b1 |=> P3_CH_DIV_OUT == $past(map_sel.d3)
		&& P2_CH_DIV_OUT == $past(map_sel.d2))
		else $error("port dividers do not follow the active map");
	sync_bit_a: assert property (
		PAIR_SYNC_OUT |-> $past(q_reg.sync))
		else $error("pair sync without the sync bit");
	spread_follow_a: assert property (
		SPREAD_EN_IN |=> SPREAD_ACT_OUT)
		else $error("spread mode not entered with pin high");
	spread_load_a: assert property (
		SPREAD_EN_IN && !q_reg.spread_q
		|=> q_reg.spa == $past(q_reg.spw))
		else $error("spread settings not adopted on pin rise");
	frac_nominal_a: assert property (
		!SPREAD_ACT_OUT |-> ##2 SDM_FRAC_OUT == $past(frac_ext))
		else $error("fraction not nominal with spread off");
	ack_foreign_a: assert property (
		q_reg.fsm == psc_pkg::I_SKIP |-> SDA_OEN_OUT)
		else $error("foreign address acknowledged");

	cover_alt_map_select_pin_c: cover property (NEW_ACQ_OUT && q_reg.alt_map_select_pin_q);
	cover_write_c: cover property (wr_en);
	cover_spread_c: cover property (SPREAD_ACT_OUT ##1 SDM_FRAC_OUT
		< frac_ext);

endmodule
`default_nettype wire

// ### test/psc_host.sv
// partner model: i2c host plus spread and alt_map_select_pin pin drivers
`timescale 1ns/10ps
`default_nettype none

module psc_host (
	// clock
	input  wire logic clk_in,
	// serial port, sda released high by pull-up
	input  wire logic sda_in,
	output logic      scl_out,
	output logic      sda_out,
	// control pins
	output logic      spread_out,
	output logic      alt_map_select_pin_out
);
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
		spread_out = 1'b0;
		alt_map_select_pin_out = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
	endtask

	// scl high four cycles, device needs at least one
	task automatic send_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= -1; i--) begin
			sda_out <= (i < 0) | b[i & 7];
			tick(2);
			scl_out <= 1'b1;
			tick(2);
			ack = ~sda_in;
			tick(2);
			scl_out <= 1'b0;
			tick(2);
		end
	endtask

	task automatic write_reg(input logic [6:0] dev, input logic [7:0] sub,
			input logic [7:0] data, output logic ok);
		logic a0, a1, a2;
		@(posedge clk_in);
		sda_out <= 1'b0;
		tick(4);
		scl_out <= 1'b0;
		tick(2);
		send_byte({dev, 1'b0}, a0);
		send_byte(sub, a1);
		send_byte(data, a2);
		sda_out <= 1'b0;
		tick(2);
		scl_out <= 1'b1;
		tick(2);
		sda_out <= 1'b1;
		tick(4);
		ok = a0 & a1 & a2;
	endtask

	task automatic set_spread(input logic v);
		@(posedge clk_in);
		spread_out <= v;
	endtask

	task automatic set_alt_map_select_pin(input logic v);
		@(posedge clk_in);
		alt_map_select_pin_out <= v;
	endtask
endmodule
`default_nettype wire

// ### test/tb_pll2_spread_alt_map_select_pin_ctrl.sv
// self-checking bench for the pll2 spread and alt_map_select_pin control
`timescale 1ns/10ps
`default_nettype none
`include "psc_map.svh"

`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin \
	err_total++; $display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end

module tb_pll2_spread_alt_map_select_pin_ctrl;
	logic              CLK_IN;
	logic              RESETN_IN;
	logic              scl, host_sda, spread, alt_map_select_pin;
	wire               sda_line;
	logic              SDA_OUT, SDA_OEN_OUT;
	logic [7:0]        FB_INT_OUT;
	logic signed [17:0] SDM_FRAC_OUT;
	logic [11:0]       MOD_WORD_OUT;
	logic [2:0]        P2_VCO_DIV_OUT, P3_VCO_DIV_OUT;
	logic [4:0]        P2_CH_DIV_OUT, P3_CH_DIV_OUT;
	logic              PAIR_SYNC_OUT, REF_DIV_TWO_OUT, NEW_ACQ_OUT;
	logic              SPREAD_ACT_OUT, BLEED_OUT, SDM_PD_OUT;
	int                err_total = 0;
	int                checks_done = 0;
	int                acq_seen = 0;

	// open drain: either party may pull the line low
	assign sda_line = host_sda & (SDA_OEN_OUT | SDA_OUT);

	// pulses can land inside a write, so count them as they stand
	always @(negedge CLK_IN)
		if (NEW_ACQ_OUT === 1'b1)
			acq_seen++;

	psc_host u_host (.clk_in(CLK_IN), .sda_in(sda_line), .scl_out(scl),
		.sda_out(host_sda), .spread_out(spread), .alt_map_select_pin_out(alt_map_select_pin));

	psc_ctrl u_dut (.CLK_IN(CLK_IN), .RESETN_IN(RESETN_IN), .SCL_IN(scl),
		.SDA_IN(sda_line), .SDA_OUT(SDA_OUT), .SDA_OEN_OUT(SDA_OEN_OUT),
		.SPREAD_EN_IN(spread), .ALT_MAP_SEL_IN(alt_map_select_pin),
		.FB_INT_OUT(FB_INT_OUT), .SDM_FRAC_OUT(SDM_FRAC_OUT),
		.MOD_WORD_OUT(MOD_WORD_OUT), .P2_VCO_DIV_OUT(P2_VCO_DIV_OUT),
		.P2_CH_DIV_OUT(P2_CH_DIV_OUT), .P3_VCO_DIV_OUT(P3_VCO_DIV_OUT),
		.P3_CH_DIV_OUT(P3_CH_DIV_OUT), .PAIR_SYNC_OUT(PAIR_SYNC_OUT),
		.REF_DIV_TWO_OUT(REF_DIV_TWO_OUT), .NEW_ACQ_OUT(NEW_ACQ_OUT),
		.SPREAD_ACT_OUT(SPREAD_ACT_OUT), .BLEED_OUT(BLEED_OUT),
		.SDM_PD_OUT(SDM_PD_OUT));

	initial begin
		CLK_IN = 1'b0;
		forever #50 CLK_IN = ~CLK_IN;
	end

	task automatic wrap_up;
		if (err_total == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic wr(input logic [7:0] sub, input logic [7:0] d);
		logic ok;
		u_host.write_reg(`PSC_I2C_ADDR, sub, d, ok);
		@(negedge CLK_IN);
		`CHK("ack", 1'b1, ok)
	endtask

	task automatic count_acq(output int n);
		n = 0;
		repeat (6) begin
			@(negedge CLK_IN);
			if (NEW_ACQ_OUT === 1'b1)
				n++;
		end
	endtask

	task automatic t_defaults;
		`CHK("fb", 7'd99, FB_INT_OUT)
		`CHK("frac", 18'sd333, SDM_FRAC_OUT)
		`CHK("mod", 12'd625, MOD_WORD_OUT)
		`CHK("divs", 16'h8490, {P2_VCO_DIV_OUT, P2_CH_DIV_OUT,
			P3_VCO_DIV_OUT, P3_CH_DIV_OUT})
		`CHK("ref", 1'b0, REF_DIV_TWO_OUT)
		`CHK("acq", 1'b0, NEW_ACQ_OUT)
	endtask

	task automatic t_primary;
		logic ok;
		wr(`PSC_A_INT_FB, 8'h05);
		`CHK("fb85", 7'd85, FB_INT_OUT)
		wr(`PSC_A_REF, 8'h02);
		`CHK("ref2", 1'b1, REF_DIV_TWO_OUT)
		wr(`PSC_A_REF, 8'h00);
		`CHK("ref1", 1'b0, REF_DIV_TWO_OUT)
		wr(`PSC_A_P2_DIV, 8'h43);
		wr(`PSC_A_SYNC, 8'h01);
		`CHK("p2", 8'h43, {P2_VCO_DIV_OUT, P2_CH_DIV_OUT})
		`CHK("nosync", 1'b0, PAIR_SYNC_OUT)
		wr(`PSC_A_P3_DIV, 8'h50);
		`CHK("sync", 1'b1, PAIR_SYNC_OUT)
		// a foreign address must leave every setting alone
		u_host.write_reg(7'h6b, `PSC_A_INT_FB, 8'h09, ok);
		@(negedge CLK_IN);
		`CHK("nack", 1'b0, ok)
		`CHK("fbkeep", 7'd85, FB_INT_OUT)
		wr(`PSC_A_INT_FB, 8'h33);
		`CHK("fb131", 8'd131, FB_INT_OUT)
		wr(`PSC_A_INT_FB, 8'h13);
		wr(`PSC_A_FRAC_HI, 8'h0c);
		wr(`PSC_A_FRAC_MOD, 8'h63);
		`CHK("frac198", 18'sd198, SDM_FRAC_OUT)
		`CHK("mod881", 12'd881, MOD_WORD_OUT)
		wr(`PSC_A_FRAC_HI, 8'h14);
		wr(`PSC_A_FRAC_MOD, 8'hd2);
		`CHK("frac333", 18'sd333, SDM_FRAC_OUT)
		`CHK("mod625", 12'd625, MOD_WORD_OUT)
	endtask

	task automatic t_alt_map_select_pin;
		int n;
		wr(`PSC_A_BIAS, 8'h04);
		wr(`PSC_A_SDM_PD, 8'h00);
		// software restart: one then zero gives a single pulse
		n = acq_seen;
		wr(`PSC_A_ACQ, 8'h01);
		wr(`PSC_A_ACQ, 8'h00);
		`CHK("soft_acq", n + 1, acq_seen)
		u_host.set_alt_map_select_pin(1'b1);
		count_acq(n);
		`CHK("acq_up", 1, n)
		`CHK("alt_fb", 7'd100, FB_INT_OUT)
		`CHK("alt_frac", 18'sd198, SDM_FRAC_OUT)
		`CHK("alt_mod", 12'd625, MOD_WORD_OUT)
		`CHK("alt_div", 16'h8490, {P2_VCO_DIV_OUT, P2_CH_DIV_OUT,
			P3_VCO_DIV_OUT, P3_CH_DIV_OUT})
		`CHK("bleed", 1'b1, BLEED_OUT)
		`CHK("sdm_pd", 1'b0, SDM_PD_OUT)
		wr(`PSC_A_ALT_INT, 8'h05);
		`CHK("alt_fb85", 7'd85, FB_INT_OUT)
		u_host.set_alt_map_select_pin(1'b0);
		count_acq(n);
		`CHK("acq_dn", 1, n)
		`CHK("prim_fb", 7'd99, FB_INT_OUT)
	endtask

	task automatic t_spread;
		logic signed [17:0] ex, lo, hi;
		int p;
		wr(`PSC_A_STEP_SZ, 8'hf9);
		wr(`PSC_A_STEP_LO, 8'h03);
		wr(`PSC_A_STEP_HI, 8'h02);
		u_host.set_spread(1'b1);
		repeat (2) @(negedge CLK_IN);
		`CHK("act", 1'b1, SPREAD_ACT_OUT)
		for (int k = 0; k < 10 && SDM_FRAC_OUT === 18'sd333; k++)
			@(negedge CLK_IN);
		// step -7, three steps each half, rate two
		for (int i = 1; i <= 12; i++) begin
			p = i % 6;
			ex = 333 - 7 * ((p <= 3) ? p : 6 - p);
			`CHK("tri", ex, SDM_FRAC_OUT)
			repeat (2) @(negedge CLK_IN);
		end
		// new values written mid-run stay dormant until a toggle
		wr(`PSC_A_STEP_SZ, 8'h80);
		wr(`PSC_A_STEP_LO, 8'h05);
		lo = 18'sd333;
		repeat (14) begin
			@(negedge CLK_IN);
			lo = (SDM_FRAC_OUT < lo) ? SDM_FRAC_OUT : lo;
		end
		`CHK("old_min", 18'sd312, lo)
		u_host.set_spread(1'b0);
		// pin sample, offset clear, then fraction register: three edges
		repeat (4) @(negedge CLK_IN);
		`CHK("nominal", 18'sd333, SDM_FRAC_OUT)
		`CHK("act_off", 1'b0, SPREAD_ACT_OUT)
		u_host.set_spread(1'b1);
		lo = 18'sd333;
		hi = 18'sd0;
		// -128 x 5 would reach -640, half percent allows only -311
		repeat (60) begin
			@(negedge CLK_IN);
			lo = (SDM_FRAC_OUT < lo) ? SDM_FRAC_OUT : lo;
			hi = (SDM_FRAC_OUT > hi) ? SDM_FRAC_OUT : hi;
		end
		`CHK("clamp_lo", 18'sd77, lo)
		`CHK("clamp_hi", 18'sd333, hi)
	endtask

	initial begin
		RESETN_IN = 1'b0;
		repeat (6) @(posedge CLK_IN);
		RESETN_IN <= 1'b1;
		repeat (3) @(negedge CLK_IN);
		t_defaults();
		t_primary();
		t_alt_map_select_pin();
		t_spread();
		wrap_up();
	end

	// whole run is near 5500 cycles
	initial begin
		repeat (30000) @(posedge CLK_IN);
		err_total++;
		wrap_up();
	end
endmodule
`default_nettype wire
